// ---- src/ocd_decode.sv ----
// Pipelined opcode fetch and operand decode for a one-clock CPU core
// Notes on behaviour
// - One machine cycle per clock; no idle bus states between fetches.
// - Fetch of the next byte overlaps decode output of the previous.
// - Each instruction starts with one 8-bit opcode from program memory.
// - Opcode decides action class and how many operand bytes follow.
// - Instructions are one, two or three bytes; exactly that many consumed.
// - Arithmetic, multiply/divide, carry ops update flags as classified.
// - Register operand selects one of eight in the current bank.
// - Direct address below 80H is RAM, 80H and above is SFR.
// - Indirect address comes from register 0 or 1 of current bank.
// - Immediates come from instruction bytes, 8-bit or 16-bit.
// - Long call/jump carry a full 16-bit target.
// - Absolute call/jump stay in the 2K page of the next instruction.
// - Relative branches add signed offset to next instruction address.
// - Bit operand names one direct bit in RAM or SFR.
`default_nettype none
module ocd_decode
  import ocd_pkg::*;
#(
  parameter int PC_W = 16
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Program memory byte stream, one byte per clock when valid
  input wire logic i_code_valid,
  input wire logic [7:0] i_code_byte,
  // Current bank select
  input wire logic [1:0] i_bank,
  // Fetch address
  output logic [PC_W-1:0] o_pc,
  // Decoded instruction, one-cycle pulse on o_dec_valid
  output logic o_dec_valid,
  output logic [7:0] o_opcode,
  output logic [1:0] o_len,
  output ocd_am_t o_am,
  output logic [7:0] o_data_addr,
  output logic o_data_is_sfr,
  output logic [2:0] o_bit_pos,
  output logic [15:0] o_imm,
  output ocd_br_t o_br,
  output logic [PC_W-1:0] o_target,
  output ocd_fx_t o_cy_fx,
  output ocd_fx_t o_ov_fx,
  output ocd_fx_t o_ac_fx
);
  typedef enum {ST_OP, ST_B2, ST_B3} ocd_st_t;
  ocd_st_t st;
  logic [PC_W-1:0] pc;
  logic [7:0] op;
  logic [7:0] b2;
  logic [1:0] len_q;
  logic dec_v;
  logic [7:0] dec_op;
  logic [1:0] dec_len;
  ocd_am_t dec_am;
  logic [7:0] dec_addr;
  logic dec_sfr;
  logic [2:0] dec_bit;
  logic [15:0] dec_imm;
  ocd_br_t dec_br;
  logic [PC_W-1:0] dec_tgt;
  ocd_fx_t dec_cy;
  ocd_fx_t dec_ov;
  ocd_fx_t dec_ac;

  // Classification of the byte in flight or the held opcode
  wire [7:0] cls_op = (st == ST_OP) ? i_code_byte : op;
  wire [1:0] c_len;
  ocd_am_t c_am;
  ocd_br_t c_br;
  ocd_fx_t c_cy;
  ocd_fx_t c_ov;
  ocd_fx_t c_ac;
  wire c_rel3;

  ocd_len_dec u_cls
  (
    .i_op(cls_op),
    .o_len(c_len),
    .o_am(c_am),
    .o_br(c_br),
    .o_cy_fx(c_cy),
    .o_ov_fx(c_ov),
    .o_ac_fx(c_ac),
    .o_rel_third(c_rel3)
  );

  // Bank register index: bank times eight plus register number
  function automatic logic [7:0] reg_addr(input logic [1:0] bank,
                                          input logic [2:0] r);
    reg_addr = {3'h0, bank, r};
  endfunction

  // Bit address to byte address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b < OCD_SFR_BASE)
      bit_byte = OCD_BITRAM_BASE + {3'h0, b[7:3]};
    else
      bit_byte = b & OCD_SFR_BIT_MASK;
  endfunction

  // Instruction ends on this byte when its count reaches the length
  wire take = i_code_valid;
  wire last_op = (st == ST_OP) && (c_len == OCD_LEN1);
  wire last_b2 = (st == ST_B2) && (len_q == OCD_LEN2);
  wire last_b3 = (st == ST_B3);
  wire fin = take && (last_op || last_b2 || last_b3);
  wire [PC_W-1:0] pc_next_ins = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [7:0] ofs = last_b3 ? i_code_byte : (last_b2 ? i_code_byte : 8'h00);
  wire [PC_W-1:0] rel_tgt = pc_next_ins + {{(PC_W-8){ofs[7]}}, ofs};
  wire [PC_W-1:0] pg_tgt = {pc_next_ins[PC_W-1:OCD_PAGE_W],
                            op[7:5], i_code_byte};
  wire [15:0] long_tgt = {b2, i_code_byte};
  wire [7:0] dir_byte = (st == ST_B3 && c_am == AM_DIR) ? b2 : i_code_byte;
  wire bit_first = (c_am == AM_BIT);

  // Next-field selection for the decoded instruction
  wire [7:0] next_addr =
    (c_am == AM_REG) ? reg_addr(i_bank, cls_op[2:0]) :
    (c_am == AM_IND) ? reg_addr(i_bank, {2'h0, cls_op[0]}) :
    (c_am == AM_BIT) ? bit_byte(st == ST_B3 ? b2 : i_code_byte) :
    (c_am == AM_DIR) ? dir_byte : 8'h00;
  wire next_sfr = (c_am == AM_DIR) && (next_addr >= OCD_SFR_BASE);
  wire next_bit_sfr = bit_first &&
    ((st == ST_B3 ? b2 : i_code_byte) >= OCD_SFR_BASE);
  wire [15:0] next_imm =
    (c_am == AM_IMM16) ? {b2, i_code_byte} :
    (c_am == AM_IMM8 && st == ST_B3) ? {8'h00, b2} :
    (c_am == AM_IMM8) ? {8'h00, i_code_byte} : 16'h0000;
  wire [PC_W-1:0] next_tgt =
    (c_br == BR_LONG) ? long_tgt[PC_W-1:0] :
    (c_br == BR_PAGE) ? pg_tgt :
    (c_br == BR_REL) ? rel_tgt : {PC_W{1'b0}};
  wire [2:0] next_bit = (st == ST_B3) ? b2[2:0] : i_code_byte[2:0];

  // Fetch sequencer: overlaps next fetch with emitting the last decode
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= ST_OP;
    else if (take)
      unique case (st)
        ST_OP: st <= (c_len == OCD_LEN1) ? ST_OP : ST_B2;
        ST_B2: st <= (len_q == OCD_LEN2) ? ST_OP : ST_B3;
        ST_B3: st <= ST_OP;
      endcase
  end

  // Program counter advances each accepted byte
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pc <= '0;
    else if (take)
      pc <= pc_next_ins;
  end

  // Held opcode and second byte
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      op <= 8'h00;
      b2 <= 8'h00;
      len_q <= OCD_LEN1;
    end
    else if (take && st == ST_OP)
    begin
      op <= i_code_byte;
      len_q <= c_len;
    end
    else if (take && st == ST_B2)
      b2 <= i_code_byte;
  end

  // Decode result registers; the pulse lands while next opcode is fetched
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dec_v <= 1'b0;
      dec_op <= 8'h00;
      dec_len <= OCD_LEN1;
      dec_am <= AM_NONE;
      dec_addr <= 8'h00;
      dec_sfr <= 1'b0;
      dec_bit <= 3'h0;
      dec_imm <= 16'h0000;
      dec_br <= BR_NONE;
      dec_tgt <= '0;
      dec_cy <= FX_KEEP;
      dec_ov <= FX_KEEP;
      dec_ac <= FX_KEEP;
    end
    else
    begin
      dec_v <= fin;
      if (fin)
      begin
        dec_op <= cls_op;
        dec_len <= (st == ST_OP) ? c_len : len_q;
        dec_am <= c_am;
        dec_addr <= next_addr;
        dec_sfr <= next_sfr || next_bit_sfr;
        dec_bit <= next_bit;
        dec_imm <= next_imm;
        dec_br <= c_br;
        dec_tgt <= next_tgt;
        dec_cy <= c_cy;
        dec_ov <= c_ov;
        dec_ac <= c_ac;
      end
    end
  end

  assign o_pc = pc;
  assign o_dec_valid = dec_v;
  assign o_opcode = dec_op;
  assign o_len = dec_len;
  assign o_am = dec_am;
  assign o_data_addr = dec_addr;
  assign o_data_is_sfr = dec_sfr;
  assign o_bit_pos = dec_bit;
  assign o_imm = dec_imm;
  assign o_br = dec_br;
  assign o_target = dec_tgt;
  assign o_cy_fx = dec_cy;
  assign o_ov_fx = dec_ov;
  assign o_ac_fx = dec_ac;

  // Checks, all on the core clock and quiet while reset is low
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Byte-taking shapes of one instruction
  sequence s_fin;
    fin;
  endsequence
  sequence s_two_taken;
    (take && st == ST_OP && c_len == OCD_LEN2) ##1 take;
  endsequence
  sequence s_three_taken;
    (take && st == ST_OP && c_len == OCD_LEN3) ##1 (take [*2]);
  endsequence

  // Pacing: one byte per taken clock, nothing moves on a stall
  chk_pulse_after_fin: assert property
    (s_fin |=> o_dec_valid)
    else $error("decode pulse missing");
  chk_no_pulse_idle: assert property
    (!fin |=> !o_dec_valid)
    else $error("spurious decode pulse");
  chk_pc_steps: assert property
    (take |=> o_pc == $past(pc) + 1'b1)
    else $error("pc not stepped");
  chk_pc_holds: assert property
    (!take |=> $stable(o_pc))
    else $error("pc moved on a stall");

  // Length of each multi-byte instruction class
  chk_len_bytes: assert property
    (s_three_taken |=> o_dec_valid && o_len == OCD_LEN3)
    else $error("three byte length wrong");
  chk_two_bytes: assert property
    (s_two_taken |=> o_dec_valid && o_len == OCD_LEN2)
    else $error("two byte length wrong");
  chk_long_len: assert property
    (o_dec_valid && o_br == BR_LONG |-> o_len == OCD_LEN3)
    else $error("long branch not three bytes");
  chk_page_len: assert property
    (o_dec_valid && o_br == BR_PAGE |-> o_len == OCD_LEN2)
    else $error("page branch not two bytes");
  chk_imm16_len: assert property
    (o_dec_valid && o_am == AM_IMM16 |-> o_len == OCD_LEN3)
    else $error("wide constant not three bytes");

  // Operand addressing; the core reads the operand itself
  chk_sfr_split: assert property
    (o_dec_valid && o_am == AM_DIR |-> o_data_is_sfr == o_data_addr[7])
    else $error("direct space split wrong");
  chk_bank_reg: assert property
    (o_dec_valid && o_am == AM_REG |-> o_data_addr[7:5] == 3'h0 &&
     o_data_addr[4:3] == $past(i_bank) && o_data_addr[2:0] == o_opcode[2:0])
    else $error("bank register out of bank area");
  chk_ind_ptr: assert property
    (o_dec_valid && o_am == AM_IND |-> o_data_addr[7:5] == 3'h0 &&
     o_data_addr[2:0] == {2'h0, o_opcode[0]} && !o_data_is_sfr)
    else $error("pointer register wrong");
  chk_bit_ram: assert property
    (o_dec_valid && o_am == AM_BIT && !o_data_is_sfr |->
     o_data_addr[7:4] == OCD_BITRAM_BASE[7:4])
    else $error("bit outside bit area");
  chk_bit_sfr: assert property
    (o_dec_valid && o_am == AM_BIT && o_data_is_sfr |->
     o_data_addr == (o_data_addr & OCD_SFR_BIT_MASK) &&
     o_data_addr >= OCD_SFR_BASE)
    else $error("bit register not aligned");

  // Flag effect codes for the fixed-effect opcodes
  chk_mul_cy: assert property
    (o_dec_valid && o_opcode == 8'hA4 |-> o_cy_fx == FX_CLR && o_ov_fx == FX_RES)
    else $error("multiply carry not cleared");
  chk_div_cy: assert property
    (o_dec_valid && o_opcode == 8'h84 |-> o_cy_fx == FX_CLR && o_ov_fx == FX_RES)
    else $error("divide carry not cleared");
  chk_set_cy: assert property
    (o_dec_valid && o_opcode == 8'hD3 |-> o_cy_fx == FX_SET)
    else $error("set carry not written");
  chk_clr_cy: assert property
    (o_dec_valid && o_opcode == 8'hC3 |-> o_cy_fx == FX_CLR)
    else $error("clear carry not written");

  // Branch targets
  chk_page_keep: assert property
    (fin && c_br == BR_PAGE |=> o_target[PC_W-1:OCD_PAGE_W] ==
     $past(pc_next_ins[PC_W-1:OCD_PAGE_W]))
    else $error("page left");
  chk_rel_third: assert property
    (fin && c_rel3 |-> st == ST_B3)
    else $error("offset not in third byte");
endmodule
`default_nettype wire

// ---- src/ocd_len_dec.sv ----
// Combinational opcode classifier: length, addressing mode, flag effects
`default_nettype none
module ocd_len_dec
  import ocd_pkg::*;
(
  // Opcode in
  input wire logic [7:0] i_op,
  // Decoded class
  output logic [1:0] o_len,
  output ocd_am_t o_am,
  output ocd_br_t o_br,
  output ocd_fx_t o_cy_fx,
  output ocd_fx_t o_ov_fx,
  output ocd_fx_t o_ac_fx,
  output logic o_rel_third
);
  wire [3:0] lo = i_op[3:0];
  wire [3:0] hi = i_op[7:4];
  wire is_rn = i_op[3];
  wire is_ri = (lo == 4'h6) || (lo == 4'h7);
  wire is_pg = (lo == 4'h1);

  // Length and operand class from the opcode byte alone
  always_comb
  begin
    o_len = OCD_LEN1;
    o_am = AM_NONE;
    o_br = BR_NONE;
    o_rel_third = 1'b0;
    if (is_pg)
    begin
      o_len = OCD_LEN2;
      o_br = BR_PAGE;
    end
    else if (i_op == 8'h02 || i_op == 8'h12)
    begin
      o_len = OCD_LEN3;
      o_br = BR_LONG;
    end
    else if (i_op == 8'h90)
    begin
      o_len = OCD_LEN3;
      o_am = AM_IMM16;
    end
    else if (i_op == 8'h80 || i_op == 8'h40 || i_op == 8'h50 ||
             i_op == 8'h60 || i_op == 8'h70)
    begin
      o_len = OCD_LEN2;
      o_br = BR_REL;
    end
    else if (i_op == 8'h10 || i_op == 8'h20 || i_op == 8'h30 ||
             i_op == 8'hD5 || (hi == 4'hB && (lo >= 4'h4)))
    begin
      o_len = OCD_LEN3;
      o_br = BR_REL;
      o_rel_third = 1'b1;
      o_am = (hi == 4'hD || i_op == 8'hB5) ? AM_DIR :
             ((hi == 4'hB) ? AM_IMM8 : AM_BIT);
    end
    else if (hi == 4'hD && is_rn)
    begin
      o_len = OCD_LEN2;
      o_br = BR_REL;
      o_am = AM_REG;
    end
    else if (i_op == 8'h75 || i_op == 8'h85 || i_op == 8'h43 ||
             i_op == 8'h53 || i_op == 8'h63)
    begin
      o_len = OCD_LEN3;
      o_am = AM_DIR;
    end
    else if (i_op == 8'h72 || i_op == 8'h82 || i_op == 8'h92 ||
             i_op == 8'hA0 || i_op == 8'hA2 || i_op == 8'hB0 ||
             i_op == 8'hB2 || i_op == 8'hC2 || i_op == 8'hD2)
    begin
      o_len = OCD_LEN2;
      o_am = AM_BIT;
    end
    else if ((lo == 4'h4 && (hi >= 4'h2) && (hi <= 4'h9) && hi != 4'h8) ||
             (hi == 4'h7 && (is_rn || is_ri)))
    begin
      o_len = OCD_LEN2;
      o_am = AM_IMM8;
    end
    else if (lo == 4'h5 || lo == 4'h2 || lo == 4'h3 ||
             ((hi == 4'h8 || hi == 4'hA) && (is_rn || is_ri)) ||
             i_op == 8'hC0 || i_op == 8'hD0)
    begin
      o_len = ((lo == 4'h2 || lo == 4'h3) && (hi < 4'h4 || hi > 4'h6))
              ? OCD_LEN1 : OCD_LEN2;
      o_am = (o_len == OCD_LEN2) ? AM_DIR : AM_NONE;
    end
    else if (is_rn)
      o_am = AM_REG;
    else if (is_ri)
      o_am = AM_IND;
  end

  // Flag effects per class
  always_comb
  begin
    o_cy_fx = FX_KEEP;
    o_ov_fx = FX_KEEP;
    o_ac_fx = FX_KEEP;
    if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && (lo >= 4'h4))
    begin
      o_cy_fx = FX_RES;
      o_ov_fx = FX_RES;
      o_ac_fx = FX_RES;
    end
    else if (i_op == 8'hA4 || i_op == 8'h84)
    begin
      o_cy_fx = FX_CLR;
      o_ov_fx = FX_RES;
    end
    else if (i_op == 8'hD3)
      o_cy_fx = FX_SET;
    else if (i_op == 8'hC3)
      o_cy_fx = FX_CLR;
    else if (i_op == 8'hD4 || i_op == 8'h13 || i_op == 8'h33 ||
             i_op == 8'hB3 || i_op == 8'h82 || i_op == 8'hB0 ||
             i_op == 8'h72 || i_op == 8'hA0 || i_op == 8'hA2 ||
             (hi == 4'hB && lo >= 4'h4))
      o_cy_fx = FX_RES;
  end
endmodule
`default_nettype wire

// ---- src/ocd_pkg.sv ----
// Package: opcode classes, addressing constants and flag effects for decode
`default_nettype none
package ocd_pkg;
  localparam int OCD_W = 8;
  localparam logic [7:0] OCD_SFR_BASE = 8'h80;
  localparam logic [7:0] OCD_BITRAM_BASE = 8'h20;
  localparam logic [7:0] OCD_SFR_BIT_MASK = 8'hF8;
  localparam logic [1:0] OCD_LEN1 = 2'h1;
  localparam logic [1:0] OCD_LEN2 = 2'h2;
  localparam logic [1:0] OCD_LEN3 = 2'h3;
  localparam int OCD_PAGE_W = 11;
  // Flag effect codes for one flag
  typedef enum logic [1:0] {FX_KEEP, FX_CLR, FX_SET, FX_RES} ocd_fx_t;
  // Addressing mode of the principal operand
  typedef enum logic [2:0] {
    AM_NONE, AM_REG, AM_DIR, AM_IND, AM_IMM8, AM_IMM16, AM_BIT
  } ocd_am_t;
  // Control transfer class
  typedef enum logic [1:0] {BR_NONE, BR_LONG, BR_PAGE, BR_REL} ocd_br_t;
endpackage
`default_nettype wire

// ---- tb/ocd_decode_test.sv ----
// Self-checking bench for the pipelined opcode decoder
`default_nettype none
module ocd_decode_test;
  import ocd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] bank = 2'h0;
  logic slow = 1'b0;
  logic code_valid;
  logic [7:0] code_byte;
  logic [15:0] pc;
  logic dec_valid;
  logic [7:0] opcode;
  logic [1:0] len;
  ocd_am_t am;
  logic [7:0] daddr;
  logic dsfr;
  logic [2:0] bpos;
  logic [15:0] imm;
  ocd_br_t br;
  logic [15:0] target;
  ocd_fx_t cy;
  ocd_fx_t ov;
  ocd_fx_t ac;
  logic [15:0] at = 16'h0000;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  ocd_decode #(.PC_W(16)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_code_valid(code_valid), .i_code_byte(code_byte), .i_bank(bank),
    .o_pc(pc), .o_dec_valid(dec_valid), .o_opcode(opcode), .o_len(len),
    .o_am(am), .o_data_addr(daddr), .o_data_is_sfr(dsfr),
    .o_bit_pos(bpos), .o_imm(imm), .o_br(br), .o_target(target),
    .o_cy_fx(cy), .o_ov_fx(ov), .o_ac_fx(ac));

  ocd_prog_mem mem_u (.i_clk(clk), .i_addr(pc), .i_slow(slow),
    .o_valid(code_valid), .o_byte(code_byte));

  task automatic cmp(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic fx3(input ocd_fx_t c, input ocd_fx_t o, input ocd_fx_t a);
    cmp("carry_flag", 16'(c), 16'(cy));
    cmp("overflow_flag", 16'(o), 16'(ov));
    cmp("aux_carry_flag", 16'(a), 16'(ac));
  endtask

  // Store one instruction at the next address and await its decode
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1,
    input logic [7:0] b2, input int n);
    int k;
    @(posedge clk);
    #1;
    mem_u.put(at, b0);
    if (n > 1)
      mem_u.put(at + 16'h0001, b1);
    if (n > 2)
      mem_u.put(at + 16'h0002, b2);
    at = at + 16'(n);
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (dec_valid !== 1'b1 && k < 40);
    cmp("dec_valid", 16'h0001, 16'(dec_valid));
    cmp("opcode", 16'(b0), 16'(opcode));
    cmp("len", 16'(n), 16'(len));
  endtask

  // Eight opcodes offered at once must decode on eight straight clocks
  task automatic sc_stream();
    int first;
    int last;
    int seen;
    first = -1;
    last = 0;
    seen = 0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++)
      mem_u.put(at + 16'(i), 8'h00);
    at = at + 16'h0008;
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clk);
      #1;
      if (dec_valid === 1'b1)
      begin
        seen++;
        last = c;
        if (first < 0)
          first = c;
      end
    end
    cmp("pulses", 16'h0008, 16'(seen));
    cmp("pulse span", 16'h0007, 16'(last - first));
    fx3(FX_KEEP, FX_KEEP, FX_KEEP);
  endtask

  task automatic sc_long();
    issue(8'h02, 8'h12, 8'h34, 3);
    cmp("br", 16'(BR_LONG), 16'(br));
    cmp("target", 16'h1234, target);
    cmp("pc", at, pc);
  endtask

  // Page jump placed so the next instruction starts a new 2K page
  task automatic sc_page();
    int k;
    @(posedge clk);
    #1;
    while (at != 16'h07FE)
    begin
      mem_u.put(at, 8'h00);
      at++;
    end
    k = 0;
    while (pc !== 16'h07FE && k < 3000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (2) @(posedge clk);
    issue(8'hE1, 8'h5A, 8'h00, 2);
    cmp("br", 16'(BR_PAGE), 16'(br));
    cmp("target", 16'h0F5A, target);
  endtask

  // Both ends of the signed offset range
  task automatic sc_rel();
    issue(8'h80, 8'h80, 8'h00, 2);
    cmp("br", 16'(BR_REL), 16'(br));
    cmp("target", at - 16'h0080, target);
    issue(8'hB4, 8'h3C, 8'h7F, 3);
    cmp("target", at + 16'h007F, target);
    cmp("carry_flag", 16'(FX_RES), 16'(cy));
  endtask

  // Direct addresses either side of the SFR boundary
  task automatic sc_dir();
    issue(8'h25, 8'h7F, 8'h00, 2);
    cmp("am", 16'(AM_DIR), 16'(am));
    cmp("addr", 16'h007F, 16'(daddr));
    cmp("sfr", 16'h0000, 16'(dsfr));
    fx3(FX_RES, FX_RES, FX_RES);
    issue(8'h35, 8'h80, 8'h00, 2);
    cmp("addr", 16'h0080, 16'(daddr));
    cmp("sfr", 16'h0001, 16'(dsfr));
  endtask

  // Bank register and indirect pointer in two different banks
  task automatic sc_reg();
    @(negedge clk);
    bank = 2'h3;
    issue(8'h2F, 8'h00, 8'h00, 1);
    cmp("am", 16'(AM_REG), 16'(am));
    cmp("addr", 16'h001F, 16'(daddr));
    @(negedge clk);
    bank = 2'h2;
    issue(8'h97, 8'h00, 8'h00, 1);
    cmp("am", 16'(AM_IND), 16'(am));
    cmp("addr", 16'h0011, 16'(daddr));
    fx3(FX_RES, FX_RES, FX_RES);
  endtask

  task automatic sc_imm();
    issue(8'h24, 8'hA5, 8'h00, 2);
    cmp("am", 16'(AM_IMM8), 16'(am));
    cmp("imm", 16'h00A5, imm);
    issue(8'h90, 8'hBE, 8'hEF, 3);
    cmp("am", 16'(AM_IMM16), 16'(am));
    cmp("imm", 16'hBEEF, imm);
  endtask

  // Last RAM bit and a bit inside an SFR
  task automatic sc_bit();
    issue(8'hA2, 8'h7F, 8'h00, 2);
    cmp("am", 16'(AM_BIT), 16'(am));
    cmp("addr", 16'h002F, 16'(daddr));
    cmp("bitpos", 16'h0007, 16'(bpos));
    cmp("sfr", 16'h0000, 16'(dsfr));
    issue(8'hA2, 8'h83, 8'h00, 2);
    cmp("addr", 16'h0080, 16'(daddr));
    cmp("bitpos", 16'h0003, 16'(bpos));
    cmp("sfr", 16'h0001, 16'(dsfr));
    cmp("carry_flag", 16'(FX_RES), 16'(cy));
  endtask

  // Multiply, divide, set, clear, rotate and decimal adjust
  task automatic sc_flags();
    logic [7:0] ops [6] = '{8'hA4, 8'h84, 8'hD3, 8'hC3, 8'h33, 8'hD4};
    ocd_fx_t cys [6] = '{FX_CLR, FX_CLR, FX_SET, FX_CLR, FX_RES, FX_RES};
    ocd_fx_t ovs [6] = '{FX_RES, FX_RES, FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP};
    for (int i = 0; i < 6; i++)
    begin
      issue(ops[i], 8'h00, 8'h00, 1);
      fx3(cys[i], ovs[i], FX_KEEP);
      cmp("am", 16'(AM_NONE), 16'(am));
      cmp("br", 16'(BR_NONE), 16'(br));
    end
  endtask

  // Memory answering every other cycle must not change the result
  task automatic sc_slow();
    @(negedge clk);
    slow = 1'b1;
    issue(8'h02, 8'hAB, 8'hCD, 3);
    cmp("target", 16'hABCD, target);
    cmp("pc", at, pc);
    @(negedge clk);
    slow = 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling far above the roughly 2100 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // Reset for four clocks, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp("pc", 16'h0000, pc);
    cmp("dec_valid", 16'h0000, 16'(dec_valid));
    rst_n = 1'b1;
    sc_stream();
    sc_long();
    sc_dir();
    sc_reg();
    sc_imm();
    sc_bit();
    sc_flags();
    sc_slow();
    sc_page();
    sc_rel();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- tb/ocd_prog_mem.sv ----
// Program memory model that feeds the opcode decoder one byte per clock, or every other clock when slow
`default_nettype none
module ocd_prog_mem
(
  // Clock and fetch address
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  // Pace select: slow offers a byte every other cycle
  input wire logic i_slow,
  // Byte stream to the decoder
  output logic o_valid,
  output logic [7:0] o_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  bit have [0:65535];
  logic skip;

  // Quiet start: nothing offered until the bench stores bytes
  initial
  begin
    skip = 1'b0;
    o_valid = 1'b0;
    o_byte = 8'h00;
  end

  // Empty slots stall; a withheld byte shows the inverse of the byte driven the clock before, so a long stall alternates old data and its inverse
  always @(negedge i_clk)
  begin
    o_valid <= have[i_addr] && !(i_slow && skip);
    o_byte <= (have[i_addr] && !(i_slow && skip)) ? mem[i_addr] : ~o_byte;
    skip <= i_slow && !skip;
  end

  // Store one program byte
  task automatic put(input logic [15:0] a, input logic [7:0] b);
    mem[a] = b;
    have[a] = 1'b1;
  endtask
endmodule
`default_nettype wire
